/* File: rtl/pmcs_flag.sv */
// Purpose: Sticky event flag, set by hardware, cleared by software
// Assumes: Set and clear arrive on the core clock
// Notes:   A set in the clearing cycle wins so no event is lost
`timescale 1ns/100ps
module pmcs_flag
  import pmcs_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);

  pmcs_flag_t s_r;
  pmcs_flag_t s_nxt;

  always_comb begin
    s_nxt   = s_r;
    s_nxt.q = set | (s_r.q & ~clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;

  chk_set_wins: assert property (
    @(posedge aclk) disable iff (!aresetn)
    set |=> q) else $error("Sticky flag lost an event");

endmodule

/* File: rtl/pmcs_pkg.sv */
// Purpose: Constants and state types for the PHY misc control/status bank
// Assumes: 10 MHz core clock, AXI4-Lite register access, 32-bit data
// Notes:   Register index times four gives the byte address
package pmcs_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int         AXI_AW    = 8;
  localparam int         IDX_W     = 6;
  localparam logic [5:0] IDX_LOOP  = 6'h16;
  localparam logic [5:0] IDX_INT   = 6'h18;
  localparam logic [5:0] IDX_STRAP = 6'h19;
  localparam logic [5:0] IDX_TDR   = 6'h1e;
  localparam logic [5:0] IDX_RST   = 6'h1f;
  localparam logic [5:0] IDX_GIC   = 6'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DEC  = 2'h3;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int B_CORE_PWR  = 8;
  localparam int B_ACK_ST    = 15;
  localparam int B_TXC_ST    = 14;
  localparam int B_POR_ST    = 11;
  localparam int B_ACK_EN    = 7;
  localparam int B_TXC_EN    = 6;
  localparam int B_POR_EN    = 3;
  localparam int B_TDR_START = 15;
  localparam int B_TDR_AUTO  = 14;
  localparam int B_TDR_DONE  = 1;
  localparam int B_TDR_FAIL  = 0;
  localparam int B_GLOB_RST  = 15;
  localparam int B_DIG_RST   = 14;
  localparam int B_FORCE     = 2;
  localparam int B_GIE       = 1;
  localparam int LOOP_W      = 7;
  localparam int MADDR_W     = 5;

  // ****************************************************************
  // Loop codes and reset values
  // ****************************************************************
  localparam logic [6:0] LB_NONE = 7'h00;
  localparam logic [6:0] LB_PCS  = 7'h01;
  localparam logic [6:0] LB_RS   = 7'h02;
  localparam logic [6:0] LB_DIG  = 7'h04;
  localparam logic [6:0] LB_ANA  = 7'h08;
  localparam logic [6:0] LB_REV  = 7'h10;
  localparam logic       POR_EN_RST   = 1'b1;
  localparam logic       GIE_RST      = 1'b1;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef struct packed {
    logic [6:0]        loop;
    logic [4:0]        loop_path;
    logic              ack_en;
    logic              txc_en;
    logic              por_en;
    logic              auto_run;
    logic              start;
    logic              done;
    logic              fail;
    logic              gie;
    logic              force_irq;
    logic [4:0]        strap_s1;
    logic [4:0]        strap_s2;
    logic [4:0]        maddr;
    logic [1:0]        strap_cnt;
    logic              link_q;
    logic              glob_rst;
    logic              dig_rst;
    logic              tdr_go;
    logic              irq;
    logic              aw_rdy;
    logic              aw_hold;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_rdy;
    logic              w_hold;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              ar_rdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } pmcs_state_t;

  typedef struct packed {
    logic q;
  } pmcs_flag_t;

endpackage

/* File: rtl/pmcs_regs.sv */
// Purpose: Loopback, power, OAM/POR interrupt, strap and cable test regs
// Assumes: Event and TDR inputs are on aclk; strap pins are asynchronous
// Notes:   AXI4-Lite slave, one write and one read in flight at a time
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
// How it works
// - Loop codes one-hot: PCS, RS, digital
// - Fourth bit analog loop, fifth reverse
// - Bit 8 reads core normal power
// - Ack received sets bit 15, enable 7
// - Tx valid clear sets 14, enable 6
// - POR done sets bit 11, enable 3
// - Interrupt register resets to 0008h
// - Strapped address read in bits 4:0
// - Start bit launches run, self clears
// - Auto-run starts test on link down
// - Done bit set after run finishes
// - Fail only meaningful while done set
// - Fail shows test result after run
// - Global enable gates the three status sources
// - Force bit drives interrupt active
module pmcs_regs
  import pmcs_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              core_normal_pwr,
  input  wire logic              oam_ack_evt,
  input  wire logic              oam_tx_valid_clr_evt,
  input  wire logic              por_done_evt,
  input  wire logic [4:0]        strap_pins,
  input  wire logic              link_up,
  input  wire logic              tdr_finish,
  input  wire logic              tdr_bad,
  output logic [4:0]             loop_path,
  output logic [4:0]             strapped_mgmt_address,
  output logic                   tdr_go,
  output logic                   glob_reset_pulse,
  output logic                   dig_reset_pulse,
  output logic                   irq
);

  pmcs_state_t s_r;
  pmcs_state_t s_nxt;
  logic        ack_st;
  logic        txc_st;
  logic        por_st;
  logic        ack_clr;
  logic        txc_clr;
  logic        por_clr;

  // ****************************************************************
  // Sticky event status
  // ****************************************************************
  pmcs_flag u_ack (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (oam_ack_evt),
    .clr     (ack_clr),
    .q       (ack_st)
  );

  pmcs_flag u_txc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (oam_tx_valid_clr_evt),
    .clr     (txc_clr),
    .q       (txc_st)
  );

  pmcs_flag u_por (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (por_done_evt),
    .clr     (por_clr),
    .q       (por_st)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [IDX_W-1:0] widx;
    logic [IDX_W-1:0] ridx;
    logic [15:0]      wd;
    logic             lo;
    logic             hi;
    logic             wr;
    logic [15:0]      rv;
    logic             hit;
    s_nxt   = s_r;
    widx    = s_r.aw_addr[AXI_AW-1:2];
    ridx    = s_axi_araddr[AXI_AW-1:2];
    wd      = s_r.w_data[15:0];
    lo      = s_r.w_strb[0];
    hi      = s_r.w_strb[1];
    wr      = s_r.aw_hold & s_r.w_hold & ~s_r.bvalid;
    rv      = '0;
    hit     = 1'b1;
    ack_clr = 1'b0;
    txc_clr = 1'b0;
    por_clr = 1'b0;

    // Strap pins: two flops, then one capture once they have settled
    s_nxt.strap_s1 = strap_pins;
    s_nxt.strap_s2 = s_r.strap_s1;
    if (s_r.strap_cnt <= STRAP_SETTLE) begin
      s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
    end
    if (s_r.strap_cnt == STRAP_SETTLE) begin
      s_nxt.maddr = s_r.strap_s2;
    end

    // Write address and data are taken independently
    if (s_axi_awvalid && s_r.aw_rdy) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.w_rdy) begin
      s_nxt.w_hold = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    if (wr) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = RESP_OKAY;
      unique case (widx)
        IDX_LOOP: begin
          if (lo) s_nxt.loop = wd[LOOP_W-1:0];
        end
        IDX_INT: begin
          if (lo) begin
            s_nxt.ack_en = wd[B_ACK_EN];
            s_nxt.txc_en = wd[B_TXC_EN];
            s_nxt.por_en = wd[B_POR_EN];
          end
          if (hi) begin
            ack_clr = wd[B_ACK_ST];
            txc_clr = wd[B_TXC_ST];
            por_clr = wd[B_POR_ST];
          end
        end
        IDX_STRAP: begin
        end
        IDX_TDR: begin
          if (hi) begin
            s_nxt.auto_run = wd[B_TDR_AUTO];
            if (wd[B_TDR_START]) s_nxt.start = 1'b1;
          end
        end
        IDX_RST: begin
          if (hi) begin
            s_nxt.glob_rst = wd[B_GLOB_RST];
            s_nxt.dig_rst  = wd[B_DIG_RST];
          end
        end
        IDX_GIC: begin
          if (lo) begin
            s_nxt.gie       = wd[B_GIE];
            s_nxt.force_irq = wd[B_FORCE];
          end
        end
        default: s_nxt.bresp = RESP_DEC;
      endcase
    end else begin
      // Reset pulses stand one cycle only
      s_nxt.glob_rst = 1'b0;
      s_nxt.dig_rst  = 1'b0;
    end
    s_nxt.aw_rdy = ~s_nxt.aw_hold & ~s_nxt.bvalid;
    s_nxt.w_rdy  = ~s_nxt.w_hold & ~s_nxt.bvalid;

    // Read: answer registered one cycle after the address is taken
    unique case (ridx)
      IDX_LOOP: begin
        rv[B_CORE_PWR]     = core_normal_pwr;
        rv[LOOP_W-1:0]     = s_r.loop;
      end
      IDX_INT: begin
        rv[B_ACK_ST] = ack_st;
        rv[B_TXC_ST] = txc_st;
        rv[B_POR_ST] = por_st;
        rv[B_ACK_EN] = s_r.ack_en;
        rv[B_TXC_EN] = s_r.txc_en;
        rv[B_POR_EN] = s_r.por_en;
      end
      IDX_STRAP: rv[MADDR_W-1:0] = s_r.maddr;
      IDX_TDR: begin
        rv[B_TDR_START] = s_r.start;
        rv[B_TDR_AUTO]  = s_r.auto_run;
        rv[B_TDR_DONE]  = s_r.done;
        rv[B_TDR_FAIL]  = s_r.fail;
      end
      IDX_RST: rv = '0;
      IDX_GIC: begin
        rv[B_GIE]   = s_r.gie;
        rv[B_FORCE] = s_r.force_irq;
      end
      default: hit = 1'b0;
    endcase
    if (s_axi_arvalid && s_r.ar_rdy) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.ar_rdy = 1'b0;
      s_nxt.rdata  = {16'h0000, rv};
      s_nxt.rresp  = hit ? RESP_OKAY : RESP_DEC;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.ar_rdy = 1'b1;
    end

    // Cable test: auto-run on a falling link, finish clears start
    s_nxt.link_q = link_up;
    if (s_r.auto_run && s_r.link_q && !link_up) begin
      s_nxt.start = 1'b1;
    end
    if (s_r.start && tdr_finish) begin
      s_nxt.start = 1'b0;
      s_nxt.done  = 1'b1;
      s_nxt.fail  = tdr_bad;
    end
    s_nxt.tdr_go = s_nxt.start & ~s_r.start;
    if (s_nxt.tdr_go) begin
      s_nxt.done = 1'b0;
      s_nxt.fail = 1'b0;
    end

    // Loop path decode; anything but a single code leaves it normal
    s_nxt.loop_path = '0;
    unique case (s_nxt.loop)
      LB_PCS:  s_nxt.loop_path[0] = 1'b1;
      LB_RS:   s_nxt.loop_path[1] = 1'b1;
      LB_DIG:  s_nxt.loop_path[2] = 1'b1;
      LB_ANA:  s_nxt.loop_path[3] = 1'b1;
      LB_REV:  s_nxt.loop_path[4] = 1'b1;
      default: s_nxt.loop_path = '0;
    endcase

    // Interrupt: force overrides, global enable gates the sources
    s_nxt.irq = s_r.force_irq
              | (s_r.gie
                 & ((ack_st & s_r.ack_en) | (txc_st & s_r.txc_en)
                  | (por_st & s_r.por_en)));
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r        <= '0;
      s_r.por_en <= POR_EN_RST;
      s_r.gie    <= GIE_RST;
      s_r.aw_rdy <= 1'b1;
      s_r.w_rdy  <= 1'b1;
      s_r.ar_rdy <= 1'b1;
    end else if (s_r.glob_rst) begin
      // Global soft reset returns the control fields to their reset values but
      // keeps the strapped address, sticky status flags and bus handshake state
      s_r           <= s_nxt;
      s_r.loop      <= LB_NONE;
      s_r.loop_path <= '0;
      s_r.ack_en    <= 1'b0;
      s_r.txc_en    <= 1'b0;
      s_r.por_en    <= POR_EN_RST;
      s_r.auto_run  <= 1'b0;
      s_r.start     <= 1'b0;
      s_r.done      <= 1'b0;
      s_r.fail      <= 1'b0;
      s_r.gie       <= GIE_RST;
      s_r.force_irq <= 1'b0;
      s_r.tdr_go    <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready         = s_r.aw_rdy;
  assign s_axi_wready          = s_r.w_rdy;
  assign s_axi_bvalid          = s_r.bvalid;
  assign s_axi_bresp           = s_r.bresp;
  assign s_axi_arready         = s_r.ar_rdy;
  assign s_axi_rvalid          = s_r.rvalid;
  assign s_axi_rdata           = s_r.rdata;
  assign s_axi_rresp           = s_r.rresp;
  assign loop_path             = s_r.loop_path;
  assign strapped_mgmt_address = s_r.maddr;
  assign tdr_go                = s_r.tdr_go;
  assign glob_reset_pulse      = s_r.glob_rst;
  assign dig_reset_pulse       = s_r.dig_rst;
  assign irq                   = s_r.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_loop_pcs: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_r.loop == LB_PCS && !s_r.glob_rst) |-> loop_path == 5'h01)
    else $error("PCS loop code not decoded");

  chk_loop_analog: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_r.loop == LB_ANA |-> loop_path == 5'h08)
    else $error("Analog loop code not decoded");

  chk_loop_normal: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_r.loop == LB_NONE |-> loop_path == 5'h00)
    else $error("Zero loop code engaged a loop");

  chk_por_en_reset: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> (s_r.por_en && !s_r.ack_en && !s_r.txc_en))
    else $error("Interrupt enables wrong after reset");

  chk_ack_status: assert property (
    @(posedge aclk) disable iff (!aresetn)
    oam_ack_evt |=> ack_st)
    else $error("Ack event not recorded");

  chk_irq_cause: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_r.gie && por_st && s_r.por_en) |=> irq)
    else $error("Enabled status did not raise interrupt");

  chk_irq_gated: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!s_r.gie && !s_r.force_irq) |=> !irq)
    else $error("Interrupt raised while globally disabled");

  chk_irq_force: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_r.force_irq |=> irq)
    else $error("Force did not drive interrupt");

  chk_tdr_finish: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_r.start && tdr_finish && !s_r.glob_rst)
      |=> (!s_r.start && s_r.done && s_r.fail == $past(tdr_bad)))
    else $error("TDR finish not reflected");

  chk_tdr_launch: assert property (
    @(posedge aclk) disable iff (!aresetn)
    tdr_go |-> (s_r.start && !s_r.done))
    else $error("TDR launch with done still set");

  chk_auto_run: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_r.auto_run && s_r.link_q && !link_up && !s_r.glob_rst && !tdr_finish)
      |=> s_r.start ##1 1'b1)
    else $error("Auto-run missed a link drop");

  chk_read_lat: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_r.ar_rdy) |=> s_axi_rvalid)
    else $error("Read answer late");

endmodule

/* File: tb/test_pmcs_regs.sv */
// Purpose: Self-checking bench for the PHY misc control/status registers
// Assumes: AXI4-Lite master tasks, one write or read in flight at a time
// Notes:   Hangs are cut by a watchdog that ends the run the same way
`timescale 1ns/100ps
module test_pmcs_regs
  import pmcs_pkg::*;
;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        pwr, link_up, tdr_bad;
  logic [3:0]  ev;
  logic [4:0]  strap, loop_path, maddr;
  logic        tdr_go, gpulse, dpulse, irq;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          n_fail, total_checks, go_cnt, g_cnt, d_cnt;

  pmcs_regs pmcs_regs_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_normal_pwr(pwr), .oam_ack_evt(ev[2]),
    .oam_tx_valid_clr_evt(ev[1]), .por_done_evt(ev[0]),
    .strap_pins(strap), .link_up(link_up), .tdr_finish(ev[3]),
    .tdr_bad(tdr_bad), .loop_path(loop_path),
    .strapped_mgmt_address(maddr), .tdr_go(tdr_go),
    .glob_reset_pulse(gpulse), .dig_reset_pulse(dpulse), .irq(irq)
  );

  // ****************************************************************
  // Clock, pulse counters, verdict
  // ****************************************************************
  always #50 aclk = ~aclk;

  always @(posedge aclk) begin
    if (tdr_go === 1'b1) go_cnt++;
    if (gpulse === 1'b1) g_cnt++;
    if (dpulse === 1'b1) d_cnt++;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    bit a, w;
    a = 0;
    w = 0;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {16'h0, d};
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Address and data may be taken at different edges
    do begin
      @(posedge aclk);
      if (!a && awready === 1'b1) begin
        a = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end while (!(a && w));
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [5:0] idx);
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp,
                        input string what);
    rd_reg(idx);
    check(rd, exp, what);
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 4'h0;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    aclk = 0;
    aresetn = 0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    pwr = 1'b1;
    link_up = 1'b1;
    tdr_bad = 1'b0;
    ev = 4'h0;
    strap = 5'h15;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;

    rd_chk(IDX_LOOP, 32'h0100, "power and loop reset");
    rd_chk(IDX_INT, 32'h0008, "int ctrl reset");
    rd_chk(IDX_STRAP, 32'h0015, "strap address");
    check(32'(maddr), 32'h15, "strap address pins");
    rd_chk(IDX_TDR, 32'h0000, "cable test reset");
    rd_chk(IDX_GIC, 32'h0002, "global int reset");
    rd_chk(6'h3f, 32'h0, "unmapped read data");
    check(32'(rs), 32'(RESP_DEC), "unmapped read resp");
    wr(6'h3f, 16'hffff);
    check(32'(rs), 32'(RESP_DEC), "unmapped write resp");
    check(32'(irq), 32'h0, "irq idle");
    $display("test reset done");

    for (int i = 0; i < 5; i++) begin
      wr(IDX_LOOP, 16'(7'h01 << i));
      check(32'(rs), 32'(RESP_OKAY), "write resp");
      rd_chk(IDX_LOOP, 32'(7'h01 << i) | 32'h100, "loop field");
      check(32'(loop_path), 32'(5'h01 << i), "loop path");
    end
    wr(IDX_LOOP, 16'h0003);
    rd_chk(IDX_LOOP, 32'h0103, "two loop bits");
    check(32'(loop_path), 32'h0, "two loop bits path");
    wr(IDX_LOOP, 16'hffff);
    rd_chk(IDX_LOOP, 32'h017f, "ro bits of loop reg");
    wr(IDX_LOOP, 16'(LB_NONE));
    rd_chk(IDX_LOOP, 32'h0100, "loop cleared");
    check(32'(loop_path), 32'h0, "no loop path");
    $display("test loopback done");

    pulse(4'b0001);
    rd_chk(IDX_INT, 32'h0808, "por done status");
    check(32'(irq), 32'h1, "por irq");
    wr(IDX_INT, 16'h0808);
    rd_chk(IDX_INT, 32'h0008, "por status cleared");
    check(32'(irq), 32'h0, "irq after clear");
    wr(IDX_INT, 16'h0000);
    pulse(4'b0100);
    rd_chk(IDX_INT, 32'h8000, "ack status");
    check(32'(irq), 32'h0, "ack masked");
    wr(IDX_INT, 16'h0080);
    rd_chk(IDX_INT, 32'h8080, "ack enabled");
    check(32'(irq), 32'h1, "ack irq");
    wr(IDX_GIC, 16'h0000);
    rd_chk(IDX_GIC, 32'h0, "global disable");
    check(32'(irq), 32'h0, "irq blocked");
    wr(IDX_GIC, 16'h0004);
    wr(IDX_INT, 16'h8000);
    rd_chk(IDX_GIC, 32'h4, "force set");
    check(32'(irq), 32'h1, "forced irq");
    wr(IDX_GIC, 16'h0002);
    wr(IDX_INT, 16'h0040);
    pulse(4'b0010);
    rd_chk(IDX_INT, 32'h4040, "tx valid clear status");
    check(32'(irq), 32'h1, "tx valid clear irq");
    wr(IDX_INT, 16'h4008);
    rd_chk(IDX_INT, 32'h0008, "all status cleared");
    check(32'(irq), 32'h0, "irq low");
    $display("test interrupts done");

    wr(IDX_TDR, 16'h8000);
    rd_chk(IDX_TDR, 32'h8000, "run in progress");
    check(32'(go_cnt), 32'h1, "run launched");
    tdr_bad <= 1'b1;
    pulse(4'b1000);
    rd_chk(IDX_TDR, 32'h0003, "failed run");
    link_up <= 1'b0;
    rd_chk(IDX_TDR, 32'h0003, "no auto start");
    check(32'(go_cnt), 32'h1, "manual mode idle");
    link_up <= 1'b1;
    wr(IDX_TDR, 16'h4000);
    link_up <= 1'b0;
    rd_chk(IDX_TDR, 32'hc000, "auto run started");
    check(32'(go_cnt), 32'h2, "auto launch");
    tdr_bad <= 1'b0;
    pulse(4'b1000);
    rd_chk(IDX_TDR, 32'h4002, "passed run");
    link_up <= 1'b1;
    $display("test cable done");

    wr(IDX_LOOP, 16'(LB_RS));
    wr(IDX_INT, 16'h00c0);
    wr(IDX_GIC, 16'h0004);
    wr(IDX_RST, 16'h8000);
    rd_chk(IDX_LOOP, 32'h0100, "loop after soft reset");
    rd_chk(IDX_GIC, 32'h0002, "gic after soft reset");
    check(32'(irq), 32'h0, "force cleared by soft reset");
    rd_chk(IDX_INT, 32'h0008, "int after soft reset");
    rd_chk(IDX_STRAP, 32'h0015, "strap kept");
    wr(IDX_RST, 16'h4000);
    rd_chk(IDX_RST, 32'h0, "reset bits self clear");
    check(32'(g_cnt), 32'h1, "global reset pulse");
    check(32'(d_cnt), 32'h1, "digital reset pulse");
    pwr <= 1'b0;
    rd_chk(IDX_LOOP, 32'h0000, "core powered down");
    $display("test soft reset done");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    $display("ERROR %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
